// file: hdl/wdtu_pkg.sv
// package of constants and types for the watchdog timer unit
package wdtu_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] WDTU_MODE_OFFS = 16'hffc2;
  localparam logic [11:0] WDTU_ADDR_MODE = 12'h000;
  localparam logic [11:0] WDTU_ADDR_WKEY = 12'h004;
  localparam logic [11:0] WDTU_ADDR_STAT = 12'h008;
  localparam logic [7:0] WDTU_MODE_RST = 8'h00;
  localparam logic [7:0] WDTU_MODE_WMASK = 8'h96;
  localparam int WDTU_BIT_RUN = 7;
  localparam int WDTU_BIT_PRIO = 4;
  localparam int WDTU_BIT_SELHI = 2;
  localparam int WDTU_BIT_SELLO = 1;
  localparam logic [1:0] WDTU_SEL_PROHIB = 2'h3;

  // ****************************************
  // counter geometry
  // ****************************************
  localparam int WDTU_PRE_W = 13;
  localparam int WDTU_CNT_W = 8;
  localparam int WDTU_TAP_0 = 8;
  localparam int WDTU_TAP_1 = 10;
  localparam int WDTU_TAP_2 = 12;

  localparam logic [1:0] WDTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDTU_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic run;
    logic prio;
    logic [1:0] sel;
  } wdtu_mode_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] code3;
    logic [7:0] code4;
  } wdtu_pwrite_t;

endpackage

// file: hdl/wdtu_prescaler.sv
// free-running prescaler that yields the watchdog count-clock ticks
`timescale 1ns/100ps
module wdtu_prescaler
  import wdtu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [WDTU_PRE_W-1:0] pre_q;
  logic [WDTU_PRE_W-1:0] pre_d;
  logic [2:0] tap;

  // never cleared by a watchdog clear, only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else if (clk_en) begin
      pre_q <= pre_d;
    end
  end

  always_comb begin
    pre_d = pre_q + {{(WDTU_PRE_W-1){1'b0}}, 1'b1};
  end

  // a tap bit wraps every 2^(n+1) clocks; the carry out of it marks a tick
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tap
      localparam int TAP = (gi == 0) ? WDTU_TAP_0 : ((gi == 1) ? WDTU_TAP_1 : WDTU_TAP_2);
      assign tap[gi] = &pre_q[TAP:0];
    end
  endgenerate

  always_comb begin
    unique case (sel)
      2'h0: tick = clk_en & tap[0];
      2'h1: tick = clk_en & tap[1];
      2'h2: tick = clk_en & tap[2];
      default: tick = 1'b0;
    endcase
  end

endmodule

// file: hdl/wdtu_top.sv
// watchdog timer unit with protected mode register and axi4-lite slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module wdtu_top
  import wdtu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_nmi_req,
  output logic wdt_overflow_irq,
  output logic nmi_wdt_first,
  output logic opcode_trap_req
);

  // ****************************************
  // write channel capture
  // ****************************************
  logic aw_hold_q;
  logic [11:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  wdtu_pwrite_t pw;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = clk_en && aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // the protected write arrives as one word on the key register: byte 0 data,
  // byte 2 and byte 3 the two code bytes; a partial write is ignored but answered okay
  always_comb begin
    pw.valid = wr_fire && (aw_addr_q == WDTU_ADDR_WKEY) && (w_strb_q == 4'hf);
    pw.data = w_data_q[7:0];
    pw.code3 = w_data_q[23:16];
    pw.code4 = w_data_q[31:24];
  end

  logic key_ok;
  logic key_bad;
  assign key_ok = pw.valid && (pw.code3 == ~pw.code4);
  assign key_bad = pw.valid && (pw.code3 != ~pw.code4);

  // ****************************************
  // mode register
  // ****************************************
  wdtu_mode_t mode_q;
  logic [7:0] mode_rd;
  logic [1:0] new_sel;

  assign new_sel = {pw.data[WDTU_BIT_SELHI], pw.data[WDTU_BIT_SELLO]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= '0;
    end else if (clk_en && key_ok) begin
      if (!mode_q.run) begin
        mode_q.prio <= pw.data[WDTU_BIT_PRIO];
        mode_q.sel <= (new_sel == WDTU_SEL_PROHIB) ? mode_q.sel : new_sel;
      end
      // settings freeze while running; run is sticky
      mode_q.run <= mode_q.run | pw.data[WDTU_BIT_RUN];
    end
  end

  always_comb begin
    mode_rd = WDTU_MODE_RST;
    mode_rd[WDTU_BIT_RUN] = mode_q.run;
    mode_rd[WDTU_BIT_PRIO] = mode_q.prio;
    mode_rd[WDTU_BIT_SELHI] = mode_q.sel[1];
    mode_rd[WDTU_BIT_SELLO] = mode_q.sel[0];
    mode_rd = mode_rd & WDTU_MODE_WMASK;
  end

  // ****************************************
  // counter and overflow
  // ****************************************
  logic tick;
  logic [WDTU_CNT_W-1:0] cnt_q;
  logic clr;
  logic ovf;

  wdtu_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .sel(mode_q.sel),
    .tick(tick)
  );

  assign clr = key_ok && pw.data[WDTU_BIT_RUN];
  assign ovf = mode_q.run && tick && (&cnt_q) && !clr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (clr) begin
        cnt_q <= '0;
      end else if (mode_q.run && tick) begin
        cnt_q <= cnt_q + {{(WDTU_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // one-cycle request pulses
  logic irq_q;
  logic trap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
      trap_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= ovf;
      trap_q <= key_bad;
    end
  end
  assign wdt_overflow_irq = irq_q;
  assign opcode_trap_req = trap_q;

  // external nmi pin passes two flops first
  logic nmi_s1_q;
  logic nmi_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
    end else if (clk_en) begin
      nmi_s1_q <= ext_nmi_req;
      nmi_s2_q <= nmi_s1_q;
    end
  end

  // arbitration only matters for simultaneous requests
  logic first_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= 1'b0;
    end else if (clk_en) begin
      first_q <= ovf && (mode_q.prio || !nmi_s2_q);
    end
  end
  assign nmi_wdt_first = first_q;

  // ****************************************
  // write response
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= WDTU_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        // the mode register itself is not plainly writable
        bresp_q <= (aw_addr_q == WDTU_ADDR_WKEY) ? WDTU_RESP_OKAY : WDTU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ****************************************
  // read channel
  // ****************************************
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= WDTU_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= WDTU_RESP_OKAY;
        unique case (s_axi_araddr)
          WDTU_ADDR_MODE: rdata_q <= {24'h0000_00, mode_rd};
          WDTU_ADDR_STAT: rdata_q <= {24'h0000_00, cnt_q};
          WDTU_ADDR_WKEY: rdata_q <= '0;
          default: begin
            rdata_q <= '0;
            rresp_q <= WDTU_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************
  // checks
  // ****************************************
  a_mode_reset: assert property (@(posedge aclk) !aresetn |=> mode_q == '0)
    else $error("mode not cleared by reset");
  a_bad_key_trap: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && key_bad |=> opcode_trap_req && $stable(mode_q))
    else $error("bad key did not trap");
  a_good_key_notrap: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && key_ok |=> !opcode_trap_req)
    else $error("good key trapped");
  a_sel_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q.run |=> $stable(mode_q.sel) && $stable(mode_q.prio))
    else $error("settings changed while running");
  a_run_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q.run |=> mode_q.run)
    else $error("run bit cleared");
  a_clear_counter: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && clr |=> cnt_q == '0 && mode_q.run)
    else $error("clear did not zero counter");
  a_sel_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q.sel != WDTU_SEL_PROHIB)
    else $error("prohibited clock select");
  a_ovf_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && mode_q.run && tick && (&cnt_q) && !clr |=> wdt_overflow_irq ##1 cnt_q == '0)
    else $error("overflow without irq");
  a_irq_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_overflow_irq |-> $past(mode_q.run))
    else $error("irq while stopped");
  a_prio_order: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_wdt_first |-> wdt_overflow_irq && ($past(mode_q.prio) || !$past(nmi_s2_q)))
    else $error("wrong nmi order");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && $past(s_axi_araddr) == WDTU_ADDR_MODE && $rose(rvalid_q) |-> rdata_q[6:5] == 2'h0 && !rdata_q[0])
    else $error("reserved bits read one");


  // ****************************************
  // handshake and timing checks
  // ****************************************
  // the bus answers must stand until taken, or a stalled master loses them
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_key_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && aw_addr_q == WDTU_ADDR_WKEY |=> s_axi_bvalid && s_axi_bresp == WDTU_RESP_OKAY)
    else $error("key write not answered okay");
  a_partial_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && aw_addr_q == WDTU_ADDR_WKEY && w_strb_q != 4'hf |=> $stable(mode_q) && !opcode_trap_req)
    else $error("partial key write acted");
  a_trap_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    opcode_trap_req |=> !opcode_trap_req)
    else $error("trap longer than one cycle");
  a_cnt_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_q.run |-> cnt_q == '0)
    else $error("counter moved while stopped");
  a_prio_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && ovf && mode_q.prio |=> nmi_wdt_first)
    else $error("watchdog lost with priority set");

  c_started: cover property (@(posedge aclk) disable iff (!aresetn) $rose(mode_q.run));
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) wdt_overflow_irq);
  c_trap: cover property (@(posedge aclk) disable iff (!aresetn) opcode_trap_req);
  c_restart: cover property (@(posedge aclk) disable iff (!aresetn) clr && mode_q.run);

endmodule

// file: dv/wdtu_top_tb_top.sv
// self-checking testbench for the watchdog timer unit
`timescale 1ns/100ps
module watchdog_timer_unit_tb_top;
  import wdtu_pkg::*;

  // ****************************************
  // clock, reset and bus signals
  // ****************************************
  localparam int CYC_LIMIT = 12000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic ext_nmi_req = 1'b0;
  logic wdt_overflow_irq;
  logic nmi_wdt_first;
  logic opcode_trap_req;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int traps = 0;
  int irqs = 0;
  int firsts = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [7:0] sel_tab [3] = '{8'h10, 8'h12, 8'h14};

  always #2 aclk = ~aclk;

  wdtu_top wdtu_top_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_nmi_req(ext_nmi_req),
    .wdt_overflow_irq(wdt_overflow_irq), .nmi_wdt_first(nmi_wdt_first),
    .opcode_trap_req(opcode_trap_req)
  );

  // trap pulses last one cycle, so they are tallied here rather than polled
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (opcode_trap_req === 1'b1) begin
      traps <= traps + 1;
    end
    if (wdt_overflow_irq !== 1'b0) begin
      irqs <= irqs + 1;
    end
    if (nmi_wdt_first !== 1'b0) begin
      firsts <= firsts + 1;
    end
    if (cyc == CYC_LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((^got === 1'bx) || !(got >= lo && got <= hi)) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // protected key word: mode byte low, code bytes in the top half
  function automatic logic [31:0] key(input logic [7:0] m, input logic good);
    return {(good ? 8'h5a : 8'h5b), 8'ha5, 8'h00, m};
  endfunction

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_mode(input logic [7:0] exp);
    axi_rd(WDTU_ADDR_MODE, rd, rr);
    chk(rd, {24'h0, exp});
  endtask

  task automatic chk_traps(input int exp);
    repeat (3) @(posedge aclk);
    chk(traps, exp);
  endtask

  task end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_mode(WDTU_MODE_RST);
    axi_rd(12'h00c, rd, rr);
    chk({rr, rd}, {WDTU_RESP_SLVERR, 32'h0000_0000});
    axi_wr(WDTU_ADDR_MODE, 32'h0000_0094, 4'hf, WDTU_RESP_SLVERR);
    rd_mode(8'h00);
    axi_wr(WDTU_ADDR_WKEY, key(8'h14, 1'b0), 4'hf, WDTU_RESP_OKAY);
    rd_mode(8'h00);
    chk_traps(1);
    axi_wr(WDTU_ADDR_WKEY, key(8'h14, 1'b1), 4'h3, WDTU_RESP_OKAY);
    rd_mode(8'h00);
    chk_traps(1);
    // unused bits set, code 11 on the select pair: only priority lands
    axi_wr(WDTU_ADDR_WKEY, key(8'h77, 1'b1), 4'hf, WDTU_RESP_OKAY);
    rd_mode(8'h10);
    for (int i = 2; i >= 0; i--) begin
      axi_wr(WDTU_ADDR_WKEY, key(sel_tab[i], 1'b1), 4'hf, WDTU_RESP_OKAY);
      rd_mode(sel_tab[i]);
    end
    chk_traps(1);
    axi_wr(WDTU_ADDR_WKEY, key(8'h90, 1'b1), 4'hf, WDTU_RESP_OKAY);
    rd_mode(8'h90);
    // select 00 ticks every 512 clocks; phase of the free prescaler is unknown
    repeat (1500) @(posedge aclk);
    axi_rd(WDTU_ADDR_STAT, rd, rr);
    chk_rng(rd, 32'h2, 32'h3);
    axi_wr(WDTU_ADDR_WKEY, key(8'h04, 1'b1), 4'hf, WDTU_RESP_OKAY);
    rd_mode(8'h90);
    repeat (600) @(posedge aclk);
    axi_rd(WDTU_ADDR_STAT, rd, rr);
    chk_rng(rd, 32'h3, 32'h5);
    axi_wr(WDTU_ADDR_WKEY, key(8'h80, 1'b1), 4'hf, WDTU_RESP_OKAY);
    axi_rd(WDTU_ADDR_STAT, rd, rr);
    chk_rng(rd, 32'h0, 32'h1);
    rd_mode(8'h90);
    // overflow needs at least 2^17 clocks, beyond this run: no request may appear early
    chk(irqs, 0);
    chk(firsts, 0);
    end_of_test();
  end
endmodule
